// file: inc/mss_regs.vh
`ifndef MSEQ_REGS_VH
`define MSEQ_REGS_VH
// sequencer state codes
`define MSEQ_ST_POWER_ON     4'h0
`define MSEQ_ST_DETECT_CHECK 4'h1
`define MSEQ_ST_DETECT       4'h2
`define MSEQ_ST_STAT_CHECK   4'h3
`define MSEQ_ST_STAT_BRAKE   4'h4
`define MSEQ_ST_DIR_CHECK    4'h5
`define MSEQ_ST_RESYNC_CHECK 4'h6
`define MSEQ_ST_REV_CHECK    4'h7
`define MSEQ_ST_REV_CL       4'h8
`define MSEQ_ST_REV_OL       4'h9
`define MSEQ_ST_COAST_CHECK  4'hA
`define MSEQ_ST_COAST        4'hB
`define MSEQ_ST_BRAKE_CHECK  4'hC
`define MSEQ_ST_BRAKE        4'hD
`define MSEQ_ST_STARTUP      4'hE
`define MSEQ_ST_CLOSED_LOOP  4'hF
// gate pattern {hs_a,hs_b,hs_c,ls_a,ls_b,ls_c}
`define MSEQ_GATE_OFF        6'h00
`define MSEQ_GATE_ALL_LS     6'h07
`define MSEQ_GATE_ALL_HS     6'h38
// timing: one duration unit in ns, clock period in ns
`define MSEQ_UNIT_NS         1000000
`define MSEQ_CLK_NS          20
`define MSEQ_UNIT_CYC        (`MSEQ_UNIT_NS / `MSEQ_CLK_NS)
// phase-state codes during drive
`define MSEQ_DRV_NONE        2'h0
`define MSEQ_DRV_OPEN_LOOP   2'h1
`define MSEQ_DRV_CLOSED_LOOP 2'h2
`define MSEQ_DRV_REVERSE     2'h3
`endif

// file: logic/mss_timer.v
`timescale 1ns/1ps
`default_nettype none
// down-counting duration timer
module mseq_timer #(
	parameter integer W_DUR  = 8,
	parameter integer UNIT   = 50000
) (
	input  wire             i_mclk,
	input  wire             i_nrst,
	input  wire             i_ce,
	input  wire             i_start,
	input  wire [W_DUR-1:0] i_dur,
	output wire             o_done
);
	reg [W_DUR-1:0] units_ff;
	reg [31:0]      tick_ff;
	reg             run_ff;
	reg             done_ff;
	assign o_done = done_ff;
	always @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			units_ff <= {W_DUR{1'b0}};
			tick_ff  <= 32'h00000000;
			run_ff   <= 1'b0;
			done_ff  <= 1'b0;
		end else if (i_ce) begin
			done_ff <= 1'b0;
			if (i_start) begin
				units_ff <= i_dur;
				tick_ff  <= 32'h00000000;
				run_ff   <= 1'b1;
			end else if (run_ff) begin
				if (units_ff == {W_DUR{1'b0}}) begin
					run_ff  <= 1'b0;
					done_ff <= 1'b1;
				end else if (tick_ff == UNIT[31:0] - 32'h00000001) begin
					tick_ff  <= 32'h00000000;
					units_ff <= units_ff - {{(W_DUR-1){1'b0}}, 1'b1};
				end else begin
					tick_ff <= tick_ff + 32'h00000001;
				end
			end
		end
	end
endmodule // mseq_timer
`default_nettype wire

// file: logic/mss_start_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "mss_regs.vh"
// Function
// [RQ1] start in power-on after power-up, standby, sleep
// [RQ2] direction change forces reverse path
// [RQ3] detect only when enabled, else brake check
// [RQ4] low back-emf means stationary
// [RQ5] stationary brake if enabled, else start-up
// [RQ6] all low sides on for brake time
// [RQ7] forward to resync, reverse to reverse check
// [RQ8] resync enabled compares back-emf, else coast
// [RQ9] high back-emf loads detect data, closed loop
// [RQ10] reverse enabled evaluates speed, else coast
// [RQ11] reverse closed loop until below handoff
// [RQ12] open loop through zero to closed loop
// [RQ13] coast if enabled, else brake check
// [RQ14] all six off for coast time
// [RQ15] brake if enabled, else start-up
// [RQ16] time or current brake, chosen side
// [RQ17] closed loop uses trapezoidal commutation
// [RQ18] detect samples phase voltages via adc
// [RQ19] start-up method then open-loop acceleration
// [RQ20] reverse shares handoff threshold and limits
// [RQ21] coast to brake check, brakes to start-up
module mseq_start_sequencer #(
	parameter integer W_BEMF = 12,
	parameter integer W_SPD  = 16,
	parameter integer W_DUR  = 8,
	parameter integer UNIT   = `MSEQ_UNIT_CYC
) (
	input  wire              i_mclk,
	input  wire              i_nrst,
	input  wire              i_ce,
	input  wire              i_restart,
	input  wire              i_dir_change,
	input  wire              i_speed_detect_enable,
	input  wire              i_stationary_brake_enable,
	input  wire              i_resynchronise_enable,
	input  wire              i_reverse_drive_enable,
	input  wire              i_coast_enable,
	input  wire              i_brake_enable,
	input  wire              i_brake_type_select,
	input  wire              i_brake_side_select,
	input  wire [W_BEMF-1:0] i_stationary_backemf_threshold,
	input  wire [W_BEMF-1:0] i_resync_backemf_minimum,
	input  wire [W_SPD-1:0]  i_loop_handoff_threshold,
	input  wire [W_DUR-1:0]  i_stationary_brake_duration,
	input  wire [W_DUR-1:0]  i_coast_time,
	input  wire [W_DUR-1:0]  i_brake_duration,
	input  wire [W_BEMF-1:0] i_brake_release_current,
	input  wire              i_adc_valid,
	input  wire [W_BEMF-1:0] i_adc_backemf,
	input  wire              i_adc_reverse,
	input  wire [W_SPD-1:0]  i_adc_speed,
	input  wire [2:0]        i_adc_sector,
	input  wire [W_BEMF-1:0] i_phase_current_max,
	input  wire              i_startup_done,
	input  wire [W_SPD-1:0]  i_drive_speed,
	output reg  [5:0]        o_gate,
	output reg               o_adc_sample,
	output reg  [1:0]        o_drive_mode,
	output reg               o_drive_load,
	output reg  [W_SPD-1:0]  o_load_speed,
	output reg  [2:0]        o_load_sector,
	output reg               o_startup_run,
	output reg               o_trapezoidal,
	output reg  [3:0]        o_state
);
	////////////////////////////////////////////////////////////////////////////
	function [5:0] brake_gate;
		input side;
		begin
			brake_gate = side ? `MSEQ_GATE_ALL_HS : `MSEQ_GATE_ALL_LS;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	reg  [3:0]       state_ff;
	reg  [3:0]       nxt_state;
	reg              dirchg_ff;
	reg              rev_ff;
	reg  [W_BEMF-1:0] bemf_ff;
	reg  [W_SPD-1:0] spd_ff;
	reg  [2:0]       sec_ff;
	reg              tmr_start;
	reg  [W_DUR-1:0] tmr_dur;
	wire             tmr_done;
	reg              started_ff;

	mseq_timer #(
		.W_DUR (W_DUR),
		.UNIT  (UNIT)
	) u_timer (
		.i_mclk  (i_mclk),
		.i_nrst  (i_nrst),
		.i_ce    (i_ce),
		.i_start (tmr_start),
		.i_dur   (tmr_dur),
		.o_done  (tmr_done)
	);

	////////////////////////////////////////////////////////////////////////////
	always @* begin
		nxt_state = state_ff;
		tmr_start = 1'b0;
		tmr_dur   = {W_DUR{1'b0}};
		case (state_ff)
			`MSEQ_ST_POWER_ON: begin
				nxt_state = `MSEQ_ST_DETECT_CHECK;
			end
			`MSEQ_ST_DETECT_CHECK: begin
				if (i_speed_detect_enable) // RQ3
					nxt_state = `MSEQ_ST_DETECT;
				else
					nxt_state = `MSEQ_ST_BRAKE_CHECK; // RQ3
			end
			`MSEQ_ST_DETECT: begin
				if (i_adc_valid) begin // RQ18
					if (i_adc_backemf < i_stationary_backemf_threshold)
						nxt_state = `MSEQ_ST_STAT_CHECK; // RQ4
					else
						nxt_state = `MSEQ_ST_DIR_CHECK; // RQ4
				end
			end
			`MSEQ_ST_STAT_CHECK: begin
				if (i_stationary_brake_enable) begin // RQ5
					nxt_state = `MSEQ_ST_STAT_BRAKE;
					tmr_start = 1'b1;
					tmr_dur   = i_stationary_brake_duration; // RQ6
				end else begin
					nxt_state = `MSEQ_ST_STARTUP; // RQ5
				end
			end
			`MSEQ_ST_STAT_BRAKE: begin
				if (tmr_done)
					nxt_state = `MSEQ_ST_STARTUP; // RQ21
			end
			`MSEQ_ST_DIR_CHECK: begin
				if (rev_ff || dirchg_ff) // RQ2
					nxt_state = `MSEQ_ST_REV_CHECK; // RQ7
				else
					nxt_state = `MSEQ_ST_RESYNC_CHECK; // RQ7
			end
			`MSEQ_ST_RESYNC_CHECK: begin
				if (!i_resynchronise_enable)
					nxt_state = `MSEQ_ST_COAST_CHECK; // RQ8
				else if (bemf_ff > i_resync_backemf_minimum) // RQ8
					nxt_state = `MSEQ_ST_CLOSED_LOOP; // RQ9
				else
					nxt_state = `MSEQ_ST_STAT_CHECK; // RQ9
			end
			`MSEQ_ST_REV_CHECK: begin
				if (!i_reverse_drive_enable)
					nxt_state = `MSEQ_ST_COAST_CHECK; // RQ10
				else if (spd_ff > i_loop_handoff_threshold) // RQ10 RQ20
					nxt_state = `MSEQ_ST_REV_CL;
				else
					nxt_state = `MSEQ_ST_REV_OL;
			end
			`MSEQ_ST_REV_CL: begin
				if (i_drive_speed <= i_loop_handoff_threshold)
					nxt_state = `MSEQ_ST_REV_OL; // RQ11
			end
			`MSEQ_ST_REV_OL: begin
				if (i_startup_done && i_drive_speed > i_loop_handoff_threshold)
					nxt_state = `MSEQ_ST_CLOSED_LOOP; // RQ12 RQ20
			end
			`MSEQ_ST_COAST_CHECK: begin
				if (i_coast_enable) begin // RQ13
					nxt_state = `MSEQ_ST_COAST;
					tmr_start = 1'b1;
					tmr_dur   = i_coast_time; // RQ14
				end else begin
					nxt_state = `MSEQ_ST_BRAKE_CHECK; // RQ13
				end
			end
			`MSEQ_ST_COAST: begin
				if (tmr_done)
					nxt_state = `MSEQ_ST_BRAKE_CHECK; // RQ21
			end
			`MSEQ_ST_BRAKE_CHECK: begin
				if (i_brake_enable) begin // RQ15
					nxt_state = `MSEQ_ST_BRAKE;
					tmr_start = 1'b1;
					tmr_dur   = i_brake_duration;
				end else begin
					nxt_state = `MSEQ_ST_STARTUP; // RQ15
				end
			end
			`MSEQ_ST_BRAKE: begin
				if (i_brake_type_select) begin
					if (i_phase_current_max < i_brake_release_current)
						nxt_state = `MSEQ_ST_STARTUP; // RQ16 RQ21
				end else if (tmr_done) begin
					nxt_state = `MSEQ_ST_STARTUP; // RQ16 RQ21
				end
			end
			`MSEQ_ST_STARTUP: begin
				if (started_ff && i_startup_done &&
					i_drive_speed > i_loop_handoff_threshold)
					nxt_state = `MSEQ_ST_CLOSED_LOOP; // RQ19 RQ20
			end
			`MSEQ_ST_CLOSED_LOOP: begin
				nxt_state = `MSEQ_ST_CLOSED_LOOP; // RQ17
			end
			default: begin
				nxt_state = `MSEQ_ST_POWER_ON;
			end
		endcase
		if (i_restart)
			nxt_state = `MSEQ_ST_POWER_ON; // RQ1
	end

	////////////////////////////////////////////////////////////////////////////
	always @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_ff      <= `MSEQ_ST_POWER_ON; // RQ1
			dirchg_ff     <= 1'b0;
			rev_ff        <= 1'b0;
			bemf_ff       <= {W_BEMF{1'b0}};
			spd_ff        <= {W_SPD{1'b0}};
			sec_ff        <= 3'h0;
			started_ff    <= 1'b0;
			o_gate        <= `MSEQ_GATE_OFF;
			o_adc_sample  <= 1'b0;
			o_drive_mode  <= `MSEQ_DRV_NONE;
			o_drive_load  <= 1'b0;
			o_load_speed  <= {W_SPD{1'b0}};
			o_load_sector <= 3'h0;
			o_startup_run <= 1'b0;
			o_trapezoidal <= 1'b0;
			o_state       <= `MSEQ_ST_POWER_ON;
		end else if (i_ce) begin
			state_ff <= nxt_state;
			o_state  <= nxt_state;
			if (state_ff == `MSEQ_ST_POWER_ON)
				dirchg_ff <= i_dir_change; // RQ2
			if (state_ff == `MSEQ_ST_DETECT && i_adc_valid) begin
				bemf_ff <= i_adc_backemf;
				spd_ff  <= i_adc_speed;
				sec_ff  <= i_adc_sector;
				rev_ff  <= i_adc_reverse;
			end
			started_ff   <= (state_ff == `MSEQ_ST_STARTUP);
			o_adc_sample <= (nxt_state == `MSEQ_ST_DETECT); // RQ18
			o_drive_load <= (state_ff == `MSEQ_ST_RESYNC_CHECK) &&
				(nxt_state == `MSEQ_ST_CLOSED_LOOP); // RQ9
			if (state_ff == `MSEQ_ST_RESYNC_CHECK || state_ff == `MSEQ_ST_REV_CHECK) begin
				o_load_speed  <= spd_ff; // RQ9
				o_load_sector <= sec_ff;
			end
			case (nxt_state)
				`MSEQ_ST_STAT_BRAKE: o_gate <= `MSEQ_GATE_ALL_LS; // RQ6
				`MSEQ_ST_BRAKE:      o_gate <= brake_gate(i_brake_side_select); // RQ16
				default:             o_gate <= `MSEQ_GATE_OFF; // RQ14
			endcase
			case (nxt_state)
				`MSEQ_ST_REV_CL:      o_drive_mode <= `MSEQ_DRV_REVERSE; // RQ11
				`MSEQ_ST_REV_OL:      o_drive_mode <= `MSEQ_DRV_OPEN_LOOP; // RQ12
				`MSEQ_ST_STARTUP:     o_drive_mode <= `MSEQ_DRV_OPEN_LOOP; // RQ19
				`MSEQ_ST_CLOSED_LOOP: o_drive_mode <= `MSEQ_DRV_CLOSED_LOOP;
				default:              o_drive_mode <= `MSEQ_DRV_NONE;
			endcase
			o_startup_run <= (nxt_state == `MSEQ_ST_STARTUP); // RQ19
			o_trapezoidal <= (nxt_state == `MSEQ_ST_CLOSED_LOOP); // RQ17
		end
	end
endmodule // mseq_start_sequencer
`default_nettype wire

// file: verif/mss_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
// motor and phase-voltage converter seen from the sequencer
module mseq_motor_model (
	input  wire logic        i_mclk,
	input  wire logic        i_nrst,
	input  wire logic        i_sample,
	input  wire logic [5:0]  i_gate,
	input  wire logic [1:0]  i_mode,
	input  wire logic [15:0] i_spd0,
	output logic             o_valid,
	output logic             o_done,
	output logic [11:0]      o_cur,
	output logic [15:0]      o_spd
);
	logic [1:0] wait_ff;
	assign o_done = o_spd > 16'h001F;
	always @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			wait_ff <= 2'h0;
			o_valid <= 1'b0;
			o_cur <= 12'h020;
			o_spd <= 16'h0000;
		end else begin
			// a result pulse every third cycle of sampling, the first three cycles in
			wait_ff <= i_sample ? (wait_ff | {1'b0, wait_ff == 2'h2}) + 2'h1 : 2'h0;
			o_valid <= i_sample && wait_ff == 2'h2;
			// current decays only while any switch conducts
			o_cur <= (i_gate == 6'h00) ? 12'h020 : o_cur - {11'h000, o_cur != 12'h000};
			o_spd <= i_sample ? i_spd0 : (i_mode == 2'h3) ? o_spd - 16'h0001 :
				(i_mode != 2'h0) ? o_spd + 16'h0001 : o_spd;
		end
	end
endmodule // mseq_motor_model
`default_nettype wire

// file: verif/mss_seq_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mseq_seq_checker #(
	parameter integer W_BEMF = 12
) (
	input wire logic              i_mclk,
	input wire logic              i_nrst,
	input wire logic              i_ce,
	input wire logic              i_restart,
	input wire logic              i_speed_detect_enable,
	input wire logic              i_stationary_brake_enable,
	input wire logic              i_brake_enable,
	input wire logic              i_brake_side_select,
	input wire logic              i_adc_valid,
	input wire logic [W_BEMF-1:0] i_adc_backemf,
	input wire logic [W_BEMF-1:0] i_stationary_backemf_threshold,
	input wire logic [5:0]        o_gate,
	input wire logic [1:0]        o_drive_mode,
	input wire logic              o_drive_load,
	input wire logic              o_trapezoidal,
	input wire logic [3:0]        o_state
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	wire go = i_ce && !i_restart;
	chk_restart_power: assert property (i_ce && i_restart |=> o_state == 4'h0)
		else $error("restart missed");
	chk_detect_gate: assert property (go && o_state == 4'h1 |=>
		o_state == ($past(i_speed_detect_enable) ? 4'h2 : 4'hC)) else $error("detect gate");
	chk_still_motor: assert property (go && o_state == 4'h2 && i_adc_valid |=>
		o_state == (($past(i_adc_backemf) < $past(i_stationary_backemf_threshold)) ?
		4'h3 : 4'h5))
		else $error("stationary decision");
	chk_stat_gate: assert property (go && o_state == 4'h3 |=>
		o_state == ($past(i_stationary_brake_enable) ? 4'h4 : 4'hE)) else $error("stat gate");
	chk_low_brake: assert property (o_state == 4'h4 |-> o_gate == 6'h07)
		else $error("stat brake gates");
	chk_coast_off: assert property (o_state == 4'hB |-> o_gate == 6'h00)
		else $error("coast gates");
	chk_brake_gate: assert property (go && o_state == 4'hC |=>
		o_state == ($past(i_brake_enable) ? 4'hD : 4'hE)) else $error("brake gate");
	chk_brake_side: assert property (o_state == 4'hD |->
		o_gate == ($past(i_brake_side_select) ? 6'h38 : 6'h07)) else $error("brake side");
	chk_resync_load: assert property ($rose(o_drive_load) |->
		o_state == 4'hF && $past(o_state) == 4'h6) else $error("load pulse");
	chk_trap_drive: assert property (o_state == 4'hF |-> o_trapezoidal && o_drive_mode == 2'h2)
		else $error("closed loop drive");
endmodule // mseq_seq_checker
bind mseq_start_sequencer mseq_seq_checker #(.W_BEMF(W_BEMF)) u_chk (.*);
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam integer U = 4;
	logic        i_mclk = 1'b0, i_nrst = 1'b0, i_ce = 1'b1, i_restart = 1'b0;
	logic        i_dir_change, i_speed_detect_enable, i_stationary_brake_enable;
	logic        i_resynchronise_enable, i_reverse_drive_enable, i_coast_enable, i_brake_enable;
	logic        i_brake_type_select, i_brake_side_select, i_adc_reverse, i_adc_valid;
	logic        i_startup_done, o_adc_sample, o_drive_load, o_startup_run, o_trapezoidal;
	logic [11:0] i_stationary_backemf_threshold, i_resync_backemf_minimum;
	logic [11:0] i_brake_release_current, i_adc_backemf, i_phase_current_max;
	logic [15:0] i_loop_handoff_threshold, i_adc_speed, i_drive_speed, o_load_speed;
	logic [7:0]  i_stationary_brake_duration, i_coast_time, i_brake_duration;
	logic [2:0]  i_adc_sector, o_load_sector;
	logic [5:0]  o_gate;
	logic [1:0]  o_drive_mode;
	logic [3:0]  o_state, s;
	logic [31:0] seed = 32'h2AB27555, r;
	integer      failures = 0, check_count = 0, cyc = 0, n [16];
	mseq_start_sequencer #(.UNIT(U)) DUT (.*);
	mseq_motor_model u_motor (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_sample(o_adc_sample),
		.i_gate(o_gate), .i_mode(o_drive_mode), .i_spd0(i_adc_speed), .o_valid(i_adc_valid),
		.o_done(i_startup_done), .o_cur(i_phase_current_max), .o_spd(i_drive_speed));
	always #10 i_mclk = ~i_mclk;
	////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// next state expected from the current one
	function automatic logic [3:0] nxt(input logic [3:0] t);
		case (t)
		4'h1: return i_speed_detect_enable ? 4'h2 : 4'hC;
		4'h2: return (i_adc_backemf < i_stationary_backemf_threshold) ? 4'h3 : 4'h5;
		4'h3: return i_stationary_brake_enable ? 4'h4 : 4'hE;
		4'h5: return (i_adc_reverse | i_dir_change) ? 4'h7 : 4'h6;
		4'h6: return !i_resynchronise_enable ? 4'hA : (i_adc_backemf > i_resync_backemf_minimum) ? 4'hF : 4'h3;
		4'h7: return !i_reverse_drive_enable ? 4'hA : (i_adc_speed > i_loop_handoff_threshold) ? 4'h8 : 4'h9;
		4'h8: return 4'h9;
		4'hA: return i_coast_enable ? 4'hB : 4'hC;
		4'hB: return 4'hC;
		4'hC: return i_brake_enable ? 4'hD : 4'hE;
		4'h9, 4'hE: return 4'hF;
		default: return 4'hE;
		endcase
	endfunction
	task automatic check(input logic [19:0] got, input logic [19:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic win(input integer got, input logic [7:0] dur);
		if (got != 0) check(got >= dur * U + 1 && got <= dur * U + 3, 1'b1);
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////
	task automatic cfg(input integer k);
		r = rnd();
		{i_adc_reverse, i_stationary_brake_enable, i_resynchronise_enable, i_reverse_drive_enable,
			i_coast_enable, i_brake_enable, i_brake_type_select, i_brake_side_select} = r[7:0];
		i_speed_detect_enable = r[8] | r[9];
		i_dir_change = r[10] & r[11];
		i_adc_backemf = r[23:12];
		i_adc_sector = r[26:24];
		r = rnd();
		i_stationary_backemf_threshold = r[11:0];
		i_resync_backemf_minimum = r[23:12];
		i_adc_speed = {10'h000, r[29:24]};
		r = rnd();
		i_stationary_brake_duration = {6'h00, r[1:0]};
		i_coast_time = {6'h00, r[3:2]};
		i_brake_duration = {6'h00, r[5:4]};
		i_brake_release_current = {7'h00, r[10:6]} | 12'h001;
		i_loop_handoff_threshold = 16'h0018;
		if (k >= 1 && k <= 3) begin
			i_speed_detect_enable = 1'b1;
			i_dir_change = 1'b0;
			i_resynchronise_enable = 1'b1;
			i_reverse_drive_enable = 1'b1;
			i_adc_reverse = k == 2;
			i_adc_backemf = i_adc_backemf | 12'h001;
			i_stationary_backemf_threshold = (k == 2) ? 12'h000 : i_adc_backemf;
			// k 1: equal to resync minimum, k 3: one above it
			i_resync_backemf_minimum = i_adc_backemf - {11'h000, k == 3};
			i_adc_speed = 16'h0019;
		end
	endtask
	task automatic one_case(input integer k);
		@(negedge i_mclk);
		cfg(k);
		i_restart = 1'b1;
		@(negedge i_mclk);
		i_restart = 1'b0;
		check(o_state, 4'h0);
		s = 4'h0;
		for (int i = 0; i < 16; i++) n[i] = 0;
		for (int c = 0; c < 300 && s !== 4'hF; c++) begin
			@(negedge i_mclk);
			n[o_state] = n[o_state] + 1;
			if (o_state !== s) begin
				check(o_state, (s == 4'h0) ? 4'h1 : nxt(s));
				if (s == 4'hD && i_brake_type_select) check(i_phase_current_max < i_brake_release_current, 1'b1);
				s = o_state;
			end
			if (o_state === 4'hE) check(o_startup_run, 1'b1);
			if (o_drive_load) check({o_load_sector, o_load_speed}, {i_adc_sector, i_adc_speed});
		end
		check(o_state, 4'hF);
		win(n[4], i_stationary_brake_duration);
		win(n[11], i_coast_time);
		if (!i_brake_type_select) win(n[13], i_brake_duration);
	endtask
	initial begin
		cfg(0);
		repeat (16) @(posedge i_mclk);
		@(negedge i_mclk);
		i_nrst = 1'b1;
		for (int k = 0; k < 120; k++) one_case(k);
		test_done();
	end
	always @(posedge i_mclk) begin
		cyc = cyc + 1;
		if (cyc == 50000) begin
			failures = failures + 1;
			test_done();
		end
	end
endmodule // testbench
`default_nettype wire
